/* rtl/uart_rx_core.sv */
/*
  Asynchronous serial receiver core: start-bit detection with majority
  vote, per-bit data recovery, parity check, and a two-entry buffer that
  carries each frame's error flags with it.
  Assumes sample_tick is a one-cycle enable at 16x (or 8x in double
  speed) the baud rate from a divider on clk, and that the character
  size stays between 5 and 9 while the receiver is enabled.
*/
// How it works
// R1: error flags travel inside the buffer entry of their own frame.
// R2: reading the data location pops the buffer and changes the shown flags.
// R3: software writes to the flag positions never alter stored flags.
// R4: software writes zero to every flag position when writing that register.
// R5: no error flag can raise an interrupt.
// R6: frame error shows the first stop bit of the head frame, inverted.
// R7: only the first stop bit is examined; extra stop bits are ignored.
// R8: overrun sets when buffer full, a character waits, and a start arrives.
// R9: overrun clears when the waiting frame moves into the buffer.
// R10: parity check runs only when enabled; select bit chooses odd or even.
// R11: parity error stored only when check enabled at arrival; valid until read.
// R12: parity error reads zero while parity checking is disabled.
// R13: disabling stops reception at once and frees the input pin.
// R14: disabling empties the receive buffer, discarding unread entries.
// R15: software flushes by reading data until receive complete clears.
// R16: sample at 16x baud normally, 8x in double speed.
// R17: count from the first low sample; vote start on 8,9,10 or 4,5,6.
// R18: two or more high start samples reject it as noise.
// R19: sampling phase resynchronises on every valid start bit.
// R20: each bit spans 16 sample states normally, 8 in double speed.
// R21: every bit is the majority of its three centre samples.
// R22: stop voted zero sets frame error; hunt starts right after its last vote.
// R23: first voting sample is 8 or 4, middle is 9 or 5.
// R24: receive complete is high exactly while the buffer holds unread data.
// R25: select bit zero checks even parity, one checks odd.
`timescale 1ns/1ps
module uart_rx_core import uart_rx_pkg::*; #(
  parameter int unsigned BUF_DEPTH = RX_BUF_DEPTH
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // configuration
  input  wire logic              rx_enable_bit,
  input  wire logic              double_speed_select,
  input  wire logic              parity_check_enable,
  input  wire logic              parity_odd_select,
  input  wire logic [3:0]        char_bits,
  input  wire logic              sample_tick,
  // serial pin
  input  wire logic              serial_input_pin,
  output logic                   rx_pin_override,
  // software side
  input  wire logic              rd_data_strobe,
  input  wire logic              status_write,
  output logic                   rx_complete_flag,
  output logic      [DATA_W-1:0] rx_data,
  output logic                   frame_error_flag,
  output logic                   overrun_flag,
  output logic                   parity_error_flag
);

  typedef struct packed {
    logic              meta;
    logic              line;
    rx_state_t         state;
    logic [4:0]        cnt;
    logic [3:0]        bit_idx;
    logic [1:0]        votes;
    logic              prev;
    logic [DATA_W-1:0] shreg;
    logic              par_err;
    rx_entry_t         pend;
    logic              pend_valid;
  } core_t;

  core_t      cur;
  core_t      next_cur;
  logic [4:0] osr;
  logic [4:0] vote_first;
  logic [4:0] vote_last;
  logic [3:0] parity_idx;
  logic [3:0] stop_idx;
  logic       in_ready;
  rx_entry_t  head;

  // right-justify the shifted-in character, upper bits zero
  function automatic logic [DATA_W-1:0] align_char(input logic [DATA_W-1:0] sh,
                                                   input logic [3:0] n);
    return sh >> (4'(DATA_W) - n);
  endfunction : align_char

  assign osr        = double_speed_select ? OSR_DOUBLE : OSR_NORMAL;           // [R16] [R20]
  assign vote_first = double_speed_select ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL; // [R23]
  assign vote_last  = vote_first + VOTE_SPAN;                                   // [R17]
  assign parity_idx = char_bits + 4'h1;
  // stop follows data and optional parity; later stop bits never counted
  assign stop_idx   = parity_idx + {3'h0, parity_check_enable};                 // [R7]

  always_comb begin
    logic [4:0] samp;
    logic       bitv;
    samp     = 5'h00;
    bitv     = 1'b0;
    next_cur = cur;
    // first flop feeds only the second
    next_cur.meta = serial_input_pin;
    next_cur.line = cur.meta;
    if (cur.pend_valid && in_ready) begin
      next_cur.pend_valid   = 1'b0;
      next_cur.pend.overrun = 1'b0;                                             // [R9]
    end
    if (!rx_enable_bit) begin
      // abandon the frame; a high must be seen again before a start
      next_cur.state        = RX_IDLE;                                          // [R13]
      next_cur.prev         = 1'b0;
      next_cur.pend_valid   = 1'b0;
      next_cur.pend.overrun = 1'b0;
    end else if (sample_tick) begin
      unique case (cur.state)
        RX_IDLE: begin
          next_cur.prev = cur.line;
          if (cur.prev && !cur.line) begin
            next_cur.state   = RX_START;                                        // [R17]
            next_cur.cnt     = 5'h01;
            next_cur.bit_idx = 4'h0;
          end
        end
        RX_START, RX_BITS: begin
          samp         = (cur.cnt == osr) ? 5'h01 : cur.cnt + 5'h01;           // [R20]
          next_cur.cnt = samp;
          if (cur.cnt == osr) begin
            next_cur.bit_idx = cur.bit_idx + 4'h1;
          end
          if (samp == vote_first) begin
            next_cur.votes[0] = cur.line;
          end
          if (samp == vote_first + 5'h01) begin
            next_cur.votes[1] = cur.line;
          end
          if (samp == vote_last) begin
            bitv = majority3(cur.votes[0], cur.votes[1], cur.line);             // [R21]
            if (cur.state == RX_START) begin
              if (bitv) begin
                next_cur.state = RX_IDLE;                                       // [R18]
                next_cur.prev  = cur.line;
              end else begin
                // phase now locked to this start bit
                next_cur.state   = RX_BITS;                                     // [R19]
                next_cur.par_err = 1'b0;
                if (cur.pend_valid && !in_ready) begin
                  next_cur.pend.overrun = 1'b1;                                 // [R8]
                end
              end
            end else if (cur.bit_idx <= char_bits) begin
              next_cur.shreg = {bitv, cur.shreg[DATA_W-1:1]};
            end else if (cur.bit_idx < stop_idx) begin
              // checker result latched with the frame, even when zero
              next_cur.par_err = parity_check_enable &&
                (^align_char(cur.shreg, char_bits) ^ bitv) != parity_odd_select; // [R10] [R11] [R25]
            end else begin
              // first stop bit decided: hunt for the next start right away
              next_cur.state = RX_IDLE;                                         // [R22]
              next_cur.prev  = cur.line;
              // a frame finishing while the older one still waits is lost
              if (!next_cur.pend_valid) begin
                next_cur.pend_valid      = 1'b1;
                next_cur.pend.data       = align_char(cur.shreg, char_bits);
                next_cur.pend.frame_err  = !bitv;                               // [R22]
                next_cur.pend.parity_err = cur.par_err;                         // [R11]
              end
            end
          end
        end
        default: begin
          next_cur.state = RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // flags ride in the entry next to their data
  rx_fifo2 #(
    .WIDTH (ENTRY_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .reset_n   (reset_n),
    .flush     (!rx_enable_bit),                                                // [R14]
    .in_valid  (cur.pend_valid),                                                // [R1]
    .in_ready  (in_ready),
    .in_data   (cur.pend),
    .out_valid (rx_complete_flag),                                              // [R24]
    .out_ready (rd_data_strobe),                                                // [R2]
    .out_data  (head)
  );

  // no write path reaches the stored flags, and none of them has an interrupt
  assign rx_pin_override   = rx_enable_bit;                                     // [R13]
  assign rx_data           = head.data;
  assign frame_error_flag  = head.frame_err;                                    // [R6] [R3] [R5]
  assign overrun_flag      = head.overrun;
  assign parity_error_flag = head.parity_err && parity_check_enable;            // [R12]

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  disable_stop_a: assert property (!rx_enable_bit |=> cur.state == RX_IDLE && !cur.pend_valid) // [R13]
    else $error("receiver kept running after disable");
  flush_flag_a: assert property (!rx_enable_bit |=> !rx_complete_flag) // [R14]
    else $error("receive complete stayed set after disable");
  flag_write_a: assert property (status_write && !rd_data_strobe && rx_enable_bit && rx_complete_flag
      |=> $stable({frame_error_flag, overrun_flag, rx_data})) // [R3]
    else $error("status write changed stored flags");
  parity_gate_a: assert property (!parity_check_enable |-> !parity_error_flag) // [R12]
    else $error("parity error visible with checking disabled");
  start_reject_a: assert property (rx_enable_bit && sample_tick && cur.state == RX_START
      && next_cur.cnt == vote_last && majority3(cur.votes[0], cur.votes[1], cur.line)
      |=> cur.state == RX_IDLE) // [R18]
    else $error("noisy start bit was accepted");
  overrun_set_a: assert property (rx_enable_bit && sample_tick && cur.state == RX_START
      && next_cur.state == RX_BITS && cur.pend_valid && !in_ready |=> cur.pend.overrun) // [R8]
    else $error("overrun not flagged on start with buffer full");
  phase_range_a: assert property (cur.state != RX_IDLE |-> cur.cnt >= 5'h01 && cur.cnt <= osr) // [R20]
    else $error("sample counter outside bit period");
  start_vote_a: assert property (cur.state == RX_IDLE && next_cur.state == RX_START
      |=> cur.cnt == 5'h01 && cur.bit_idx == 4'h0) // [R17]
    else $error("start count did not begin at sample one");
  frame_err_a: assert property (rx_enable_bit && cur.state == RX_BITS && next_cur.state == RX_IDLE
      && !cur.pend_valid |=> cur.pend_valid && cur.pend.frame_err == !$past(majority3(
      cur.votes[0], cur.votes[1], cur.line))) // [R22]
    else $error("frame error does not match voted stop bit");
  complete_flag_a: assert property (rx_complete_flag && !rd_data_strobe && rx_enable_bit
      |=> rx_complete_flag) // [R24]
    else $error("receive complete dropped without a read");

  frame_done_c: cover property (cur.state == RX_BITS ##1 cur.state == RX_IDLE && cur.pend_valid);
  overrun_c: cover property (overrun_flag && rx_complete_flag);
  reject_c: cover property (cur.state == RX_START ##1 cur.state == RX_IDLE);
  double_c: cover property (double_speed_select && frame_error_flag);

endmodule : uart_rx_core

/* rtl/uart_rx_pkg.sv */
/*
  Shared constants and types of the asynchronous serial receiver core:
  oversampling ratios, voting positions, frame limits, the receive
  buffer entry and the receiver state encoding.
  Assumes a single system clock; no other package is needed.
*/
package uart_rx_pkg;

  // widest character: nine data bits
  localparam int unsigned DATA_W       = 9;
  localparam int unsigned RX_BUF_DEPTH = 2;

  // samples per bit and first voting sample, normal and double speed
  localparam logic [4:0] OSR_NORMAL        = 5'h10;
  localparam logic [4:0] OSR_DOUBLE        = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [4:0] VOTE_SPAN         = 5'h02;

  // legal character sizes
  localparam logic [3:0] CHAR_BITS_MIN = 4'h5;
  localparam logic [3:0] CHAR_BITS_MAX = 4'h9;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              frame_err;
    logic              overrun;
    logic              parity_err;
  } rx_entry_t;

  localparam int unsigned ENTRY_W = $bits(rx_entry_t);

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_BITS
  } rx_state_t;

  function automatic logic majority3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : majority3

endpackage : uart_rx_pkg

/* rtl/rx_fifo2.sv */
/*
  Small shifting receive buffer with valid/ready on both sides.
  The oldest entry always sits in slot 0, so the read side sees flops.
  Assumes one clock domain and a flush that outranks push and pop.
*/
`timescale 1ns/1ps
module rx_fifo2 #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // control
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0]               count;
  } fifo_t;

  fifo_t cur;
  fifo_t next_cur;
  logic  push;
  logic  pop;

  // no pass-through when full: keeps in_ready free of out_ready
  assign in_ready  = cur.count != CW'(DEPTH);
  assign out_valid = cur.count != '0;
  assign out_data  = cur.mem[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_ready && out_valid;

  always_comb begin
    next_cur = cur;
    if (pop) begin
      for (int i = 0; i < int'(DEPTH) - 1; i++) begin
        next_cur.mem[i] = cur.mem[i+1];
      end
    end
    if (push) begin
      next_cur.mem[cur.count - CW'(pop)] = in_data;
    end
    next_cur.count = cur.count + CW'(push) - CW'(pop);
    if (flush) begin
      next_cur.count = '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  read_advance_a: assert property (pop && !push && !flush |=> cur.count == $past(cur.count) - CW'(1)) // [R2]
    else $error("buffer read did not advance the read position");
  flush_empty_a: assert property (flush |=> !out_valid) // [R14]
    else $error("flush left entries in the buffer");
  fill_full_c: cover property (push ##1 push ##1 !in_ready);

endmodule : rx_fifo2

/* verification/uart_tx_model.sv */
/*
  Behavioural remote transmitter that drives the receive line.
  Assumes the bench's sample_tick; every bit length is given in ticks.
*/
`timescale 1ns/1ps
module uart_tx_model (
  // clock and tick
  input  wire logic clk,
  input  wire logic sample_tick,
  // serial line, idle high
  output logic      line
);
  initial line = 1'b1;

  // line moves on the rising edge just after a tick edge, never on a falling edge;
  // each bit still spans exactly k ticks, so bits chain without gaps
  task automatic bit_out(input logic v, input logic [4:0] k);
    @(posedge clk);
    line <= v;
    repeat (k) begin
      @(posedge clk);
      while (sample_tick !== 1'b1) @(posedge clk);
    end
  endtask : bit_out

  // start, data lsb first, optional parity, one stop of stop_len ticks;
  // longer stops just look like idle to the receiver
  task automatic send(input logic [8:0] d, input logic [3:0] n, input logic [4:0] osr,
                      input logic pen, input logic podd, input logic bad,
                      input logic stop, input logic [4:0] stop_len);
    logic p;
    p = (^(d & ((9'h001 << n) - 9'h001))) ^ podd ^ bad;
    bit_out(1'b0, osr);
    for (int i = 0; i < n; i++) bit_out(d[i], osr);
    if (pen) bit_out(p, osr);
    bit_out(stop, stop_len);
  endtask : send
endmodule : uart_tx_model

/* verification/tb_uart_rx_core.sv */
/*
  Self-checking bench for uart_rx_core: random frames in both speeds and
  all parity modes, parity and frame errors, noise starts, back-to-back
  overrun, disable in mid-frame.
  Assumes uart_tx_model on the line and a sample tick every fourth clock.
*/
`timescale 1ns/1ps
module tb_uart_rx_core;
  import uart_rx_pkg::*;

  logic              clk, reset_n, rx_enable_bit, double_speed_select;
  logic              parity_check_enable, parity_odd_select;
  bit                sample_tick;
  logic              serial_input_pin, rd_data_strobe, status_write, rx_pin_override;
  logic              rx_complete_flag, frame_error_flag, overrun_flag, parity_error_flag;
  logic [3:0]        char_bits, n;
  logic [DATA_W-1:0] rx_data, d;
  bit   [1:0]        tcnt;
  logic [4:0]        osr;
  logic              bad, stp;
  int                fails, n_checks, cyc;

  uart_rx_core u_dut (.clk(clk), .reset_n(reset_n), .rx_enable_bit(rx_enable_bit),
    .double_speed_select(double_speed_select), .parity_check_enable(parity_check_enable),
    .parity_odd_select(parity_odd_select), .char_bits(char_bits),
    .sample_tick(sample_tick), .serial_input_pin(serial_input_pin),
    .rx_pin_override(rx_pin_override), .rd_data_strobe(rd_data_strobe),
    .status_write(status_write), .rx_complete_flag(rx_complete_flag),
    .rx_data(rx_data), .frame_error_flag(frame_error_flag),
    .overrun_flag(overrun_flag), .parity_error_flag(parity_error_flag));

  uart_tx_model u_tx (.clk(clk), .sample_tick(sample_tick), .line(serial_input_pin));

  always #12.5 clk = ~clk;

  // fast tick keeps frames short; whole run is well under the ceiling
  always @(posedge clk) begin
    tcnt        <= tcnt + 2'h1;
    sample_tick <= (tcnt == 2'h3);
    cyc         <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
                       input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wait_rxc;
    int k;
    k = 0;
    @(negedge clk);
    while (rx_complete_flag !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_rxc

  // flags are looked at before the pop, as software must
  task automatic rd(input logic [DATA_W-1:0] ed, input logic fe, input logic ov,
                    input logic pe);
    wait_rxc();
    check(9'(rx_complete_flag), 9'h001, "ready");
    check(rx_data, ed, "data");
    check(9'(frame_error_flag), 9'(fe), "frame");
    check(9'(overrun_flag), 9'(ov), "overrun");
    check(9'(parity_error_flag), 9'(pe), "parity");
    @(posedge clk) rd_data_strobe <= 1'b1;
    @(posedge clk) rd_data_strobe <= 1'b0;
  endtask : rd

  // configuration changes only while disabled, so no frame sees a mix
  task automatic cfg(input logic ds, input logic pe_en, input logic odd,
                     input logic [3:0] nb);
    @(posedge clk);
    rx_enable_bit       <= 1'b0;
    double_speed_select <= ds;
    parity_check_enable <= pe_en;
    parity_odd_select   <= odd;
    char_bits           <= nb;
    @(posedge clk) rx_enable_bit <= 1'b1;
    osr = ds ? OSR_DOUBLE : OSR_NORMAL;
  endtask : cfg

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    rx_enable_bit = 1'b1;
    double_speed_select = 1'b0;
    parity_check_enable = 1'b0;
    parity_odd_select = 1'b0;
    char_bits = 4'h8;
    rd_data_strobe = 1'b0;
    status_write = 1'b0;
    fails = 0;
    n_checks = 0;
    osr = OSR_NORMAL;
    void'($urandom(32'h3a67d1b0));
    repeat (5) @(posedge clk);
    @(negedge clk);
    check(9'(rx_complete_flag), 9'h000, "reset ready");
    check(9'(rx_pin_override), 9'h001, "pin owned");
    @(posedge clk) reset_n <= 1'b1;
    // every speed and parity mode, random sizes, gaps, stops and parity faults
    for (int i = 0; i < 16; i++) begin
      n = 4'h5 + 4'($urandom % 5);
      cfg(i[2], i[1], i[0], n);
      d = 9'($urandom) & ((9'h001 << n) - 9'h001);
      bad = 1'($urandom);
      stp = ($urandom % 4) != 0;
      u_tx.bit_out(1'b1, 5'($urandom % 20 + 1));
      u_tx.send(d, n, osr, i[1], i[0], bad, stp, osr + 5'($urandom % 16));
      @(posedge clk) status_write <= 1'b1;
      @(posedge clk) status_write <= 1'b0;
      rd(d, ~stp, 1'b0, i[1] & bad);
    end
    // stored parity error hidden while checking is off
    cfg(1'b0, 1'b1, 1'b1, 4'h8);
    u_tx.bit_out(1'b1, 5'h04);
    u_tx.send(9'h0a5, 4'h8, osr, 1'b1, 1'b1, 1'b1, 1'b1, 5'h10);
    wait_rxc();
    @(posedge clk) parity_check_enable <= 1'b0;
    @(negedge clk) check(9'(parity_error_flag), 9'h000, "parity off");
    @(posedge clk) parity_check_enable <= 1'b1;
    rd(9'h0a5, 1'b0, 1'b0, 1'b1);
    // low pulse with only the first vote sample low is noise
    for (int j = 0; j < 2; j++) begin
      cfg(j[0], 1'b0, 1'b0, 4'h8);
      u_tx.bit_out(1'b1, 5'h04);
      u_tx.bit_out(1'b0, j[0] ? 5'h04 : 5'h08);
      u_tx.bit_out(1'b1, 5'h1f);
      @(negedge clk) check(9'(rx_complete_flag), 9'h000, "noise");
      u_tx.send(9'h066, 4'h8, osr, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
      rd(9'h066, 1'b0, 1'b0, 1'b0);
    end
    // four frames at the earliest restart: third flags overrun, fourth lost
    cfg(1'b0, 1'b0, 1'b0, 4'h8);
    u_tx.bit_out(1'b1, 5'h04);
    for (int j = 0; j < 4; j++) begin
      u_tx.send(9'h031 + 9'(j), 4'h8, osr, 1'b0, 1'b0, 1'b0, 1'b1, 5'h0a);
    end
    u_tx.bit_out(1'b1, 5'h10);
    rd(9'h031, 1'b0, 1'b0, 1'b0);
    rd(9'h032, 1'b0, 1'b0, 1'b0);
    rd(9'h033, 1'b0, 1'b1, 1'b0);
    @(negedge clk) check(9'(rx_complete_flag), 9'h000, "lost frame");
    u_tx.send(9'h05a, 4'h8, osr, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    rd(9'h05a, 1'b0, 1'b0, 1'b0);
    // disable with one entry held and a frame in flight
    u_tx.send(9'h0c3, 4'h8, osr, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    wait_rxc();
    u_tx.bit_out(1'b0, 5'h10);
    u_tx.bit_out(1'b1, 5'h05);
    @(posedge clk) rx_enable_bit <= 1'b0;
    repeat (3) @(negedge clk);
    check(9'(rx_complete_flag), 9'h000, "flushed");
    check(9'(rx_pin_override), 9'h000, "pin freed");
    @(posedge clk) rx_enable_bit <= 1'b1;
    repeat (6) u_tx.bit_out(1'b1, 5'h1f);
    @(negedge clk) check(9'(rx_complete_flag), 9'h000, "abandoned");
    u_tx.send(9'h03c, 4'h8, osr, 1'b0, 1'b0, 1'b0, 1'b1, 5'h10);
    rd(9'h03c, 1'b0, 1'b0, 1'b0);
    // read while empty is ignored
    @(posedge clk) rd_data_strobe <= 1'b1;
    @(posedge clk) rd_data_strobe <= 1'b0;
    @(negedge clk) check(9'(rx_complete_flag), 9'h000, "empty read");
    end_sim();
  end
endmodule : tb_uart_rx_core
